/* File: e1ac_control.v */
// e1ac_control.v: automatic alarm control and common control registers of one e1 framer.
// assumes line-side status and bit strobes are on clk; port write signals are synchronised here, reads are not.
`timescale 1ns/100ps
`include "e1ac_defs.vh"

// Behaviour
// - with auto ais on, all ones go out on frame loss, ais received or carrier loss.
// - with auto rai on, rai goes out on those same causes or missing crc4 multiframe in 128 ms.
// - with auto rai on and crc4 multiframe still missing after 400 ms, rai is sent constantly.
// - block function select routes the channel block registers to the pin or to signaling.
// - receive signaling reinsert puts signaling back into the receive serial stream when set.
// - transmit hardware signaling insert merges the signaling pin into transmit data when set.
// - the backplane clock select picks 1.544 or 2.048 MHz operation.
// - carrier loss needs 255 zeros, or 2048 with the alternate criteria bit.
// - the remote loopback bit enables loopback when one.
module e1ac_control #(
  parameter MF_SHORT_CYCLES = `E1AC_MF_SHORT_MS * `E1AC_CLK_KHZ,
  parameter MF_LONG_CYCLES = `E1AC_MF_LONG_MS * `E1AC_CLK_KHZ
)(
  input wire clk,
  input wire rst_n,
  input wire cs_n,
  input wire wr_n,
  input wire rd_n,
  input wire [7:0] addr,
  input wire [7:0] wdata,
  output reg [7:0] rdata,
  input wire rx_frame_loss,
  input wire rx_ais_detect,
  input wire rx_bit_strobe,
  input wire rx_bit_data,
  input wire crc4_enable,
  input wire rx_fas_sync,
  input wire rx_mf_sync,
  input wire rx_sig_bit_slot,
  input wire rx_sig_bit,
  input wire rx_data_in,
  input wire tx_sig_bit_slot,
  input wire tx_signaling_in,
  input wire tx_serial_in,
  input wire [4:0] tx_slot,
  input wire tx_slot_data_valid,
  input wire [7:0] tx_slot_data,
  input wire [31:0] tx_channel_block_regs,
  output reg rx_carrier_loss,
  output reg tx_send_ais,
  output reg tx_send_rai,
  output reg rx_serial_out,
  output reg tx_data_out,
  output reg tx_channel_block_out,
  output reg tx_sig_insert_select,
  output reg tx_elastic_store_enable,
  output reg tx_backplane_clock_select,
  output reg remote_loopback,
  output reg [7:0] tx_channel_monitor_reg
);

reg [7:0] alarm_control_register;
reg [7:0] signaling_and_clock_control;
reg [7:0] loopback_and_monitor_select;
reg [1:0] wr_sync;
reg wr_seen;
reg [7:0] addr_sync1;
reg [7:0] addr_sync2;
reg [7:0] wdata_sync1;
reg [7:0] wdata_sync2;
reg [11:0] zero_count;
reg [31:0] mf_count;
reg mf_short_late;
reg mf_long_late;
wire write_now;
wire aais;
wire ara;
wire common_cause;
wire [11:0] zero_limit;

////////////////////////////////////////////////////////////////////////////////
// control port: write strobe is asynchronous, so it is synchronised and edge taken once

assign write_now = wr_sync[1] & ~wr_seen;

always @(posedge clk or negedge rst_n)
begin
  if (!rst_n)
  begin
    wr_sync <= 2'h0;
    wr_seen <= 1'b0;
    addr_sync1 <= 8'h00;
    addr_sync2 <= 8'h00;
    wdata_sync1 <= 8'h00;
    wdata_sync2 <= 8'h00;
    alarm_control_register <= `E1AC_ALARM_RST;
    signaling_and_clock_control <= `E1AC_SIGCLK_RST;
    loopback_and_monitor_select <= `E1AC_LBMON_RST;
  end
  else
  begin
    wr_sync <= {wr_sync[0], ~cs_n & ~wr_n};
    wr_seen <= wr_sync[1];
    // address and data pass the same two stages as the strobe, so all three line up
    addr_sync1 <= addr;
    addr_sync2 <= addr_sync1;
    wdata_sync1 <= wdata;
    wdata_sync2 <= wdata_sync1;
    if (write_now)
    begin
      case (addr_sync2)
        `E1AC_ADDR_ALARM: alarm_control_register <= wdata_sync2;
        `E1AC_ADDR_SIGCLK: signaling_and_clock_control <= wdata_sync2 & `E1AC_SIGCLK_WMASK;
        `E1AC_ADDR_LBMON: loopback_and_monitor_select <= wdata_sync2 & `E1AC_LBMON_WMASK;
        default: ;
      endcase
    end
  end
end

// reads are combinational from register contents; unmapped addresses read zero
always @*
begin
  rdata = 8'h00;
  if (!cs_n && !rd_n)
  begin
    case (addr)
      `E1AC_ADDR_ALARM: rdata = alarm_control_register;
      `E1AC_ADDR_SIGCLK: rdata = signaling_and_clock_control;
      `E1AC_ADDR_LBMON: rdata = loopback_and_monitor_select;
      default: rdata = 8'h00;
    endcase
  end
end

////////////////////////////////////////////////////////////////////////////////
// carrier loss and crc4 multiframe timers

assign zero_limit = signaling_and_clock_control[`E1AC_B_CARRIER_LOSS_ALT_CRITERIA] ? `E1AC_ZEROS_ALT : `E1AC_ZEROS_STD;

always @(posedge clk or negedge rst_n)
begin
  if (!rst_n)
  begin
    zero_count <= 12'h000;
    rx_carrier_loss <= 1'b0;
    mf_count <= 32'h0000_0000;
    mf_short_late <= 1'b0;
    mf_long_late <= 1'b0;
  end
  else
  begin
    // a one ends the run; the clear wins so the stale count cannot raise loss again
    if (rx_bit_strobe && rx_bit_data)
    begin
      zero_count <= 12'h000;
      rx_carrier_loss <= 1'b0;
    end
    else
    begin
      if (rx_bit_strobe && zero_count < zero_limit)
        zero_count <= zero_count + 12'h001;
      if (zero_count >= zero_limit)
        rx_carrier_loss <= 1'b1;
    end
    if (!crc4_enable || !rx_fas_sync)
    begin
      mf_count <= 32'h0000_0000;
      mf_short_late <= 1'b0;
      mf_long_late <= 1'b0;
    end
    else if (rx_mf_sync)
    begin
      // constant rai outlives a late multiframe find; only losing fas or crc4 mode ends it
      mf_count <= 32'h0000_0000;
      mf_short_late <= 1'b0;
    end
    else
    begin
      if (mf_count < MF_LONG_CYCLES)
        mf_count <= mf_count + 32'h0000_0001;
      if (mf_count >= MF_SHORT_CYCLES)
        mf_short_late <= 1'b1;
      if (mf_count >= MF_LONG_CYCLES)
        mf_long_late <= 1'b1;
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// alarm generation and data path steering

assign aais = alarm_control_register[`E1AC_B_AAIS];
assign ara = alarm_control_register[`E1AC_B_ARA];
assign common_cause = rx_frame_loss | rx_ais_detect | rx_carrier_loss;

always @(posedge clk or negedge rst_n)
begin
  if (!rst_n)
  begin
    tx_send_ais <= 1'b0;
    tx_send_rai <= 1'b0;
    rx_serial_out <= 1'b0;
    tx_data_out <= 1'b0;
    tx_channel_block_out <= 1'b0;
    tx_sig_insert_select <= 1'b0;
    tx_elastic_store_enable <= 1'b0;
    tx_backplane_clock_select <= 1'b0;
    remote_loopback <= 1'b0;
    tx_channel_monitor_reg <= 8'h00;
  end
  else
  begin
    // auto ais; both enables set is illegal, ais then wins
    tx_send_ais <= aais & common_cause;
    tx_send_rai <= ara & ~aais & (common_cause | mf_short_late | mf_long_late);
    rx_serial_out <= (signaling_and_clock_control[`E1AC_B_RX_SIGNALING_REINSERT_ENABLE] & rx_sig_bit_slot) ?
                     rx_sig_bit : rx_data_in;
    tx_data_out <= (signaling_and_clock_control[`E1AC_B_TX_HW_SIGNALING_INSERT_ENABLE] & tx_sig_bit_slot) ?
                   tx_signaling_in : tx_serial_in;
    tx_channel_block_out <= ~signaling_and_clock_control[`E1AC_B_TX_BLOCK_FUNCTION_SELECT] &
                            tx_channel_block_regs[tx_slot];
    tx_sig_insert_select <= signaling_and_clock_control[`E1AC_B_TX_BLOCK_FUNCTION_SELECT] &
                            tx_channel_block_regs[tx_slot];
    tx_elastic_store_enable <= signaling_and_clock_control[`E1AC_B_TX_ELASTIC_STORE_ENABLE];
    tx_backplane_clock_select <= signaling_and_clock_control[`E1AC_B_TX_BACKPLANE_CLOCK_SELECT];
    remote_loopback <= loopback_and_monitor_select[`E1AC_B_RLB];
    if (tx_slot_data_valid &&
        tx_slot == loopback_and_monitor_select[`E1AC_F_TCM_HI:`E1AC_F_TCM_LO])
      tx_channel_monitor_reg <= tx_slot_data;
  end
end

endmodule

/* File: e1ac_control_chk.sv */
// port assertions for e1ac_control
// assumes one clock domain and binding by port name
`timescale 1ns/100ps
module e1ac_control_chk (
  input logic clk, rst_n, cs_n, rd_n,
  input logic [7:0] addr, rdata,
  input logic rx_frame_loss, rx_ais_detect, rx_bit_strobe, rx_bit_data,
  input logic rx_carrier_loss, tx_send_ais, tx_send_rai
);
  logic [11:0] zc;
  logic rd;
  assign rd = !cs_n && !rd_n;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // saturating so a long run never wraps to a short count
  always @(posedge clk or negedge rst_n)
    if (!rst_n)
      zc <= 12'h000;
    else if (rx_bit_strobe)
      zc <= rx_bit_data ? 12'h000 : zc + {11'h000, zc != 12'hFFF};
////////////////////////////////////////
  chk_ais_cause: assert property (
    $rose(tx_send_ais) |-> $past(rx_frame_loss || rx_ais_detect || rx_carrier_loss))
    else $error("ais without a receive alarm");
  chk_alarm_excl: assert property (
    tx_send_ais |-> !tx_send_rai) else $error("ais and rai together");
  chk_loss_count: assert property (
    $rose(rx_carrier_loss) |-> zc >= 12'h0FF) else $error("carrier loss too early");
  chk_loss_clear: assert property (
    rx_bit_strobe && rx_bit_data |-> ##[1:2] !rx_carrier_loss) else $error("loss kept");
  chk_idle_bus: assert property (
    cs_n |-> rdata == 8'h00) else $error("read data while idle");
  chk_unmapped_read: assert property (
    rd && !(addr inside {8'h1A, 8'h1B, 8'hA8}) |-> rdata == 8'h00) else $error("unmapped");
  chk_spare_sig: assert property (
    rd && addr == 8'h1B |-> !rdata[4]) else $error("spare bit set");
  chk_spare_mon: assert property (
    rd && addr == 8'hA8 |-> rdata[6:5] == 2'h0) else $error("spare bits set");
  cover property ($rose(tx_send_ais));
  cover property ($rose(tx_send_rai));
  cover property ($rose(rx_carrier_loss));
endmodule
bind e1ac_control e1ac_control_chk u_chk (.*);

/* File: e1ac_control_tb_top.sv */
// register, carrier loss and alarm tests for e1ac_control
// assumes the line model and checker are compiled first
`timescale 1ns/100ps
module e1ac_control_tb_top;
  logic clk = 0, rst_n = 0, cs_n = 1, wr_n = 1, rd_n = 1, send_zeros = 0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, tx_slot_data = 8'h00, rdata, tx_channel_monitor_reg;
  logic rx_frame_loss = 0, rx_ais_detect = 0, crc4_enable = 0, rx_fas_sync = 0, rx_mf_sync = 0;
  logic rx_sig_bit_slot = 0, tx_sig_bit_slot = 0, rx_sig_bit = 0, tx_signaling_in = 0;
  logic rx_data_in = 0, tx_serial_in = 0, tx_slot_data_valid = 0, rx_bit_strobe, rx_bit_data;
  logic [4:0] tx_slot = 5'h00;
  logic [31:0] tx_channel_block_regs = 32'h00000001;
  logic rx_carrier_loss, tx_send_ais, tx_send_rai, rx_serial_out, tx_data_out;
  logic tx_channel_block_out, tx_sig_insert_select, tx_elastic_store_enable;
  logic tx_backplane_clock_select, remote_loopback;
  logic [7:0] pat [5] = '{8'h80, 8'h40, 8'h02, 8'h0C, 8'h00};
  int err_count = 0, checked = 0;
  always #4 clk = ~clk;
  e1ac_line_model line (.clk(clk), .rst_n(rst_n), .send_zeros(send_zeros),
    .bit_strobe(rx_bit_strobe), .bit_data(rx_bit_data));
  e1ac_control #(.MF_SHORT_CYCLES(100), .MF_LONG_CYCLES(300)) uut (.*);
////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    {cs_n, wr_n, addr, wdata} = {2'b00, a, d};
    tick(4);
    {cs_n, wr_n} = 2'b11;
    tick(4);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    {cs_n, rd_n, addr} = {2'b00, a};
    tick(1);
    chk(rdata, exp);
    {cs_n, rd_n} = 2'b11;
    tick(1);
  endtask
  // strobe is looked at 1 ns after an edge, so the following edge is the one that samples it
  task automatic bits(input int n);
    repeat (n)
    begin
      while (!rx_bit_strobe) tick(1);
      tick(1);
    end
    tick(2);
  endtask
  // bits(1) first aligns so the next strobe carries the new level
  task automatic zrun(input int n, input logic [1:0] al);
    bits(1);
    send_zeros = 1;
    bits(n - 1);
    chk(rx_carrier_loss, 0);
    bits(1);
    tick(2);
    chk({rx_carrier_loss, tx_send_ais, tx_send_rai}, {1'b1, al});
    send_zeros = 0;
    bits(1);
    chk(rx_carrier_loss, 0);
  endtask
  task summarize;
    $display("comparisons %0d, mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
////////////////////////////////////////
  initial
  begin
    #400000;
    err_count++;
    summarize();
  end
  initial
  begin
    tick(5);
    rst_n = 1;
    tick(1);
    rd(8'h1B, 8'h00);
    rd(8'hA8, 8'h00);
    wr(8'h55, 8'hFF);
    rd(8'h55, 8'h00);
    wr(8'h1B, 8'hFF);
    rd(8'h1B, 8'hEF);
    wr(8'hA8, 8'hFF);
    rd(8'hA8, 8'h9F);
    chk(remote_loopback, 1);
    wr(8'hA8, 8'h00);
    chk(remote_loopback, 0);
    {rx_sig_bit_slot, tx_sig_bit_slot, rx_sig_bit, tx_signaling_in} = 4'hF;
    foreach (pat[i])
    begin
      wr(8'h1B, pat[i]);
      chk({tx_elastic_store_enable, tx_sig_insert_select,
        tx_backplane_clock_select, rx_serial_out, tx_data_out},
        {pat[i][7:6], pat[i][1], pat[i][3:2]});
      chk(tx_channel_block_out, !pat[i][6]);
    end
    {rx_sig_bit_slot, tx_sig_bit_slot, rx_data_in, tx_serial_in} = 4'h3;
    tick(3);
    chk({rx_serial_out, tx_data_out}, 2'b11);
    for (int a = 0; a < 2; a++)
    begin
      wr(8'h1A, a ? 8'h10 : 8'h20);
      for (int c = 1; c < 4; c++)
      begin
        {rx_frame_loss, rx_ais_detect} = c[1:0];
        tick(3);
        chk({tx_send_ais, tx_send_rai}, a ? 2'b01 : 2'b10);
        {rx_frame_loss, rx_ais_detect} = 2'b00;
        tick(3);
        chk({tx_send_ais, tx_send_rai}, 2'b00);
      end
    end
    zrun(255, 2'b01);
    wr(8'h1A, 8'h20);
    wr(8'h1B, 8'h01);
    zrun(2048, 2'b10);
    // only the slot named in the monitor field may land in the monitor register
    wr(8'hA8, 8'h03);
    {tx_slot, tx_slot_data, tx_slot_data_valid} = {5'h03, 8'hA5, 1'b1};
    tick(1);
    {tx_slot, tx_slot_data} = {5'h04, 8'h5A};
    tick(1);
    tx_slot_data_valid = 0;
    tick(1);
    chk(tx_channel_monitor_reg, 8'hA5);
    wr(8'h1A, 8'h10);
    {crc4_enable, rx_fas_sync} = 2'b11;
    tick(90);
    chk(tx_send_rai, 0);
    tick(20);
    chk(tx_send_rai, 1);
    rx_mf_sync = 1;
    tick(3);
    chk(tx_send_rai, 0);
    rx_mf_sync = 0;
    tick(320);
    rx_mf_sync = 1;
    tick(3);
    chk(tx_send_rai, 1);
    // mid-run reset must drop the latched alarm, the monitor register and the A8 and 1A registers
    rst_n = 0;
    tick(1);
    chk(tx_send_rai, 0);
    chk(tx_channel_monitor_reg, 8'h00);
    rst_n = 1;
    tick(2);
    rd(8'hA8, 8'h00);
    rd(8'h1A, 8'h00);
    summarize();
  end
endmodule

/* File: e1ac_defs.vh */
// e1ac_defs.vh: register offsets, bit positions and timing counts for the e1ac block.
// assumes a byte-wide parallel control port and a 125 MHz core clock.
`ifndef E1AC_DEFS_VH
`define E1AC_DEFS_VH
`define E1AC_ADDR_ALARM 8'h1A
`define E1AC_ADDR_SIGCLK 8'h1B
`define E1AC_ADDR_LBMON 8'hA8
`define E1AC_ALARM_RST 8'h00
`define E1AC_SIGCLK_RST 8'h00
`define E1AC_LBMON_RST 8'h00
`define E1AC_SIGCLK_WMASK 8'hEF
`define E1AC_LBMON_WMASK 8'h9F
`define E1AC_B_AAIS 5
`define E1AC_B_ARA 4
`define E1AC_B_TX_ELASTIC_STORE_ENABLE 7
`define E1AC_B_TX_BLOCK_FUNCTION_SELECT 6
`define E1AC_B_RX_SIGNALING_REINSERT_ENABLE 3
`define E1AC_B_TX_HW_SIGNALING_INSERT_ENABLE 2
`define E1AC_B_TX_BACKPLANE_CLOCK_SELECT 1
`define E1AC_B_CARRIER_LOSS_ALT_CRITERIA 0
`define E1AC_B_RLB 7
`define E1AC_F_TCM_HI 4
`define E1AC_F_TCM_LO 0
`define E1AC_ZEROS_STD 12'h0FF
`define E1AC_ZEROS_ALT 12'h800
`define E1AC_MF_SHORT_MS 128
`define E1AC_MF_LONG_MS 400
`define E1AC_CLK_KHZ 125000
`endif

/* File: e1ac_line_model.sv */
// far-end line: one received bit every 4 clocks
// assumes the core clock; send_zeros picks the bit value
`timescale 1ns/100ps
module e1ac_line_model (
  input logic clk,
  input logic rst_n,
  input logic send_zeros,
  output logic bit_strobe,
  output logic bit_data
);
  logic [1:0] ph;
  always @(posedge clk or negedge rst_n)
    if (!rst_n)
      {ph, bit_strobe, bit_data} <= 4'h1;
    else
      // data toggles between bits so a stale level never passes for a bit
      {ph, bit_strobe, bit_data} <= {ph + 2'h1, ph == 2'h3, ph == 2'h3 ? !send_zeros : !bit_data};
endmodule
